/* mfd_cfg.svh */
`ifndef MFD_CFG_SVH
`define MFD_CFG_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define MFD_ADDR_COMMON_THS   7'h17
`define MFD_ADDR_DEB_COUNT    7'h18
`define MFD_ADDR_X_THS_HIGH   7'h73
`define MFD_ADDR_X_THS_LOW    7'h74
`define MFD_ADDR_Y_THS_HIGH   7'h75
`define MFD_ADDR_Y_THS_LOW    7'h76
`define MFD_ADDR_Z_THS_HIGH   7'h77
`define MFD_ADDR_Z_THS_LOW    7'h78

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define MFD_BIT_CLEAR_MODE    7
`define MFD_BIT_AXIS_SEL      7
`define MFD_BIT_TRANS_SHARE   7
`define MFD_LOW_FIELD_LSB     2
`define MFD_RESET_BYTE        8'h00
`define MFD_RESET_FIELD6      6'h00
`define MFD_RESET_FIELD7      7'h00

// ----------------------------------------------------------------
// Timing: debounce base step of 1.25 ms at a 40 ns clock
// ----------------------------------------------------------------
`define MFD_STEP_BASE_NS      1250000
`define MFD_CLK_PERIOD_NS     40
`define MFD_STEP_BASE_CYCLES  (`MFD_STEP_BASE_NS / `MFD_CLK_PERIOD_NS)

// Shared-threshold scale, output counts per 63 mg threshold count
`define MFD_SCALE_2G          9'h102
`define MFD_SCALE_4G          9'h081
`define MFD_SCALE_8G          9'h040

`endif

/* mfd_pkg.sv */
package mfd_pkg;

  typedef logic [12:0] mfd_ths_t;
  typedef logic [13:0] mfd_mag_t;

  typedef enum logic [1:0] {
    MFD_FS_2G = 2'h0,
    MFD_FS_4G = 2'h1,
    MFD_FS_8G = 2'h2
  } mfd_fs_t;

  typedef enum logic [1:0] {
    MFD_PM_NORMAL              = 2'h0,
    MFD_PM_LOW_POWER_LOW_NOISE = 2'h1,
    MFD_PM_HIGH_RES            = 2'h2,
    MFD_PM_LOW_POWER           = 2'h3
  } mfd_pmode_t;

  typedef enum logic [2:0] {
    MFD_ODR_800  = 3'h0,
    MFD_ODR_400  = 3'h1,
    MFD_ODR_200  = 3'h2,
    MFD_ODR_100  = 3'h3,
    MFD_ODR_50   = 3'h4,
    MFD_ODR_12P5 = 3'h5,
    MFD_ODR_6P25 = 3'h6,
    MFD_ODR_1P56 = 3'h7
  } mfd_odr_t;

endpackage

/* mfd_threshold_debounce.sv */
`include "mfd_cfg.svh"

// Operation
// RULE1: Selection off: all axes use shared 7-bit threshold, 63 mg per count.
// RULE2: Selection on: shared threshold ignored, each axis uses its own threshold.
// RULE3: Per-axis thresholds are 13-bit magnitudes scaled like output data.
// RULE4: Software never sets axis-select and transient-share bits together.
// RULE5: Freefall mode: every enabled axis magnitude below its threshold.
// RULE6: Motion mode: at least one enabled axis magnitude above its threshold.
// RULE7: Threshold bits 12..6 in high byte 6..0, bits 5..0 in low 7..2.
// RULE8: X high bit 7 selects per-axis, Y high bit 7 shares transient.
// RULE9: Event flag sets when debounce counter reaches programmed count.
// RULE10: Debounce counter saturates at programmed count.
// RULE11: Debounce step follows data rate and power mode.
// RULE12: Clear-mode bit decides counter action on non-qualifying steps.
// RULE13: Clear mode 1 zeroes counter; mode 0 decrements, stopping at zero.
// RULE14: While latching, new per-axis flags do not update the source flags.
// RULE15: Qualifying step below programmed count increments counter by one.
// RULE16: Threshold and count fields reset to zero.
module mfd_threshold_debounce #(
  parameter int unsigned STEP_BASE_CYCLES = `MFD_STEP_BASE_CYCLES,
  parameter int unsigned DATA_W           = 14
) (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic              reg_we_i,
  input  wire logic              reg_re_i,
  input  wire logic [6:0]        reg_addr_i,
  input  wire logic [7:0]        reg_wdata_i,
  output logic      [7:0]        reg_rdata_o,
  input  wire logic              sample_valid_i,
  input  wire logic [DATA_W-1:0] accel_x_i,
  input  wire logic [DATA_W-1:0] accel_y_i,
  input  wire logic [DATA_W-1:0] accel_z_i,
  input  wire logic [2:0]        axis_en_i,
  input  wire logic              motion_mode_i,
  input  wire logic              latch_en_i,
  input  wire logic              src_clear_i,
  input  wire logic [1:0]        full_scale_range_i,
  input  wire logic [2:0]        odr_sel_i,
  input  wire logic [1:0]        power_mode_i,
  output logic                   event_o,
  output logic      [2:0]        axis_flags_o,
  output logic      [2:0]        axis_neg_o,
  output logic      [7:0]        debounce_o,
  output logic                   trans_share_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic       clear_mode_q;
  logic [6:0] common_ths_q;
  logic [7:0] count_q;
  logic       axis_sel_q;
  logic       trans_share_q;
  logic [6:0] ths_hi_q [3];
  logic [5:0] ths_lo_q [3];

  wire wr_common = reg_we_i && (reg_addr_i == `MFD_ADDR_COMMON_THS);
  wire wr_count  = reg_we_i && (reg_addr_i == `MFD_ADDR_DEB_COUNT);
  wire wr_xhi    = reg_we_i && (reg_addr_i == `MFD_ADDR_X_THS_HIGH);
  wire wr_yhi    = reg_we_i && (reg_addr_i == `MFD_ADDR_Y_THS_HIGH);

  wire [6:0] hi_addr [3];
  wire [6:0] lo_addr [3];
  assign hi_addr[0] = `MFD_ADDR_X_THS_HIGH;
  assign hi_addr[1] = `MFD_ADDR_Y_THS_HIGH;
  assign hi_addr[2] = `MFD_ADDR_Z_THS_HIGH;
  assign lo_addr[0] = `MFD_ADDR_X_THS_LOW;
  assign lo_addr[1] = `MFD_ADDR_Y_THS_LOW;
  assign lo_addr[2] = `MFD_ADDR_Z_THS_LOW;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      clear_mode_q  <= 1'b0;
      common_ths_q  <= `MFD_RESET_FIELD7; // see RULE16
      count_q       <= `MFD_RESET_BYTE; // see RULE16
      axis_sel_q    <= 1'b0;
      trans_share_q <= 1'b0;
    end else begin
      if (wr_common) begin
        clear_mode_q <= reg_wdata_i[`MFD_BIT_CLEAR_MODE];
        common_ths_q <= reg_wdata_i[6:0];
      end
      if (wr_count) begin
        count_q <= reg_wdata_i;
      end
      if (wr_xhi) begin
        axis_sel_q <= reg_wdata_i[`MFD_BIT_AXIS_SEL]; // see RULE8
      end
      if (wr_yhi) begin
        trans_share_q <= reg_wdata_i[`MFD_BIT_TRANS_SHARE]; // see RULE8
      end
    end
  end

  // Per-axis threshold byte pairs and compare
  logic [2:0] below;
  logic [2:0] above;
  logic [2:0] neg;
  logic [15:0] common_scaled;
  logic [8:0]  scale;

  assign scale = (full_scale_range_i == mfd_pkg::MFD_FS_2G) ? `MFD_SCALE_2G :
                 (full_scale_range_i == mfd_pkg::MFD_FS_4G) ? `MFD_SCALE_4G : `MFD_SCALE_8G;
  // Shared threshold is in 63 mg units, so it is converted into output counts
  // Widen both factors first: a 7x9-bit product would wrap at 9 bits
  assign common_scaled = 16'(common_ths_q) * 16'(scale); // see RULE1

  wire [DATA_W-1:0] accel [3];
  assign accel[0] = accel_x_i;
  assign accel[1] = accel_y_i;
  assign accel[2] = accel_z_i;

  for (genvar a = 0; a < 3; a++) begin : g_axis
    wire we_hi = reg_we_i && (reg_addr_i == hi_addr[a]);
    wire we_lo = reg_we_i && (reg_addr_i == lo_addr[a]);
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        ths_hi_q[a] <= `MFD_RESET_FIELD7; // see RULE16
        ths_lo_q[a] <= `MFD_RESET_FIELD6; // see RULE16
      end else begin
        if (we_hi) begin
          ths_hi_q[a] <= reg_wdata_i[6:0]; // see RULE7
        end
        if (we_lo) begin
          ths_lo_q[a] <= reg_wdata_i[7:`MFD_LOW_FIELD_LSB]; // see RULE7
        end
      end
    end
    wire mfd_pkg::mfd_ths_t axis_ths = {ths_hi_q[a], ths_lo_q[a]}; // see RULE3
    wire        sign_bit = accel[a][DATA_W-1];
    wire [DATA_W-1:0] mag = sign_bit ? DATA_W'(~accel[a] + 1'b1) : accel[a];
    wire [15:0] mag16 = 16'(mag);
    wire [15:0] thr   = axis_sel_q ? 16'(axis_ths) : common_scaled; // see RULE2
    assign below[a] = axis_en_i[a] && (mag16 < thr);
    assign above[a] = axis_en_i[a] && (mag16 > thr);
    assign neg[a]   = axis_en_i[a] && sign_bit;
  end

  // Freefall needs every enabled axis low; with no axis enabled nothing fires
  wire all_low  = (axis_en_i != 3'h0) && ((below | ~axis_en_i) == 3'h7); // see RULE5
  wire any_high = (above != 3'h0); // see RULE6
  wire cond_now = motion_mode_i ? any_high : all_low;

  // ----------------------------------------------------------------
  // Sample capture and debounce step timer
  // ----------------------------------------------------------------
  logic       cond_q;
  logic [2:0] hit_q;
  logic [2:0] neg_q;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cond_q <= 1'b0;
      hit_q  <= 3'h0;
      neg_q  <= 3'h0;
    end else if (sample_valid_i) begin
      cond_q <= cond_now;
      hit_q  <= motion_mode_i ? above : below;
      neg_q  <= neg;
    end
  end

  // Step length in units of 1.25 ms
  function automatic logic [7:0] step_units(input logic [2:0] odr, input logic [1:0] pm);
    logic [7:0] base;
    base = 8'h01 << odr;
    if (pm == mfd_pkg::MFD_PM_HIGH_RES && odr > mfd_pkg::MFD_ODR_400) begin
      step_units = 8'h02;
    end else if (odr <= mfd_pkg::MFD_ODR_50) begin
      step_units = base;
    end else if (pm == mfd_pkg::MFD_PM_NORMAL) begin
      step_units = 8'h10;
    end else if (pm == mfd_pkg::MFD_PM_LOW_POWER && odr != mfd_pkg::MFD_ODR_12P5) begin
      step_units = 8'h80;
    end else begin
      step_units = 8'h40;
    end
  endfunction

  logic [15:0] base_cnt_q;
  logic [7:0]  unit_cnt_q;
  wire         base_done = (base_cnt_q == 16'(STEP_BASE_CYCLES - 1));
  wire [7:0]   step_len  = step_units(odr_sel_i, power_mode_i); // see RULE11
  wire         step_tick = base_done && (unit_cnt_q >= step_len - 8'h01);

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      base_cnt_q <= 16'h0000;
      unit_cnt_q <= 8'h00;
    end else begin
      base_cnt_q <= base_done ? 16'h0000 : base_cnt_q + 16'h0001;
      if (step_tick) begin
        unit_cnt_q <= 8'h00;
      end else if (base_done) begin
        unit_cnt_q <= unit_cnt_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Debounce counter and event flags
  // ----------------------------------------------------------------
  logic [7:0] deb_q;
  logic [7:0] deb_d;
  logic       flag_q;
  logic [2:0] axis_q;
  logic [2:0] neg_out_q;

  always_comb begin
    deb_d = deb_q;
    if (deb_q > count_q) begin
      deb_d = count_q; // see RULE10
    end else if (step_tick) begin
      if (cond_q) begin
        deb_d = (deb_q < count_q) ? deb_q + 8'h01 : deb_q; // see RULE15
      end else if (clear_mode_q) begin // see RULE12
        deb_d = 8'h00; // see RULE13
      end else if (deb_q != 8'h00) begin
        deb_d = deb_q - 8'h01; // see RULE13
      end
    end
  end

  wire reached  = (deb_q == count_q) && (count_q != 8'h00 || cond_q); // see RULE9
  wire hold_src = latch_en_i && flag_q && !src_clear_i;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      deb_q     <= 8'h00;
      flag_q    <= 1'b0;
      axis_q    <= 3'h0;
      neg_out_q <= 3'h0;
    end else begin
      deb_q <= deb_d;
      if (!hold_src) begin // see RULE14
        flag_q    <= reached;
        axis_q    <= reached ? hit_q : 3'h0;
        neg_out_q <= reached ? (neg_q & hit_q) : 3'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  logic [7:0] rd_sel;
  always_comb begin
    unique case (reg_addr_i)
      `MFD_ADDR_COMMON_THS: rd_sel = {clear_mode_q, common_ths_q};
      `MFD_ADDR_DEB_COUNT:  rd_sel = count_q;
      `MFD_ADDR_X_THS_HIGH: rd_sel = {axis_sel_q, ths_hi_q[0]};
      `MFD_ADDR_X_THS_LOW:  rd_sel = {ths_lo_q[0], 2'h0};
      `MFD_ADDR_Y_THS_HIGH: rd_sel = {trans_share_q, ths_hi_q[1]};
      `MFD_ADDR_Y_THS_LOW:  rd_sel = {ths_lo_q[1], 2'h0};
      `MFD_ADDR_Z_THS_HIGH: rd_sel = {1'b0, ths_hi_q[2]};
      `MFD_ADDR_Z_THS_LOW:  rd_sel = {ths_lo_q[2], 2'h0};
      default:              rd_sel = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_re_i) begin
      reg_rdata_o <= rd_sel;
    end
  end

  assign event_o       = flag_q;
  assign axis_flags_o  = axis_q;
  assign axis_neg_o    = neg_out_q;
  assign debounce_o    = deb_q;
  // Transient sharing is only passed on; software keeps it exclusive of axis select
  assign trans_share_o = trans_share_q; // see RULE4

endmodule // mfd_threshold_debounce

/* mfd_threshold_debounce_sva.sv */
module mfd_threshold_debounce_chk (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       reg_we_i,
  input wire logic       reg_re_i,
  input wire logic [6:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       event_o,
  input wire logic [7:0] debounce_o,
  input wire logic       trans_share_o
);
  // ----
  // Shadow of the count register
  // ----
  logic [7:0] cnt_q;
  logic       map_w;
  logic       low_w;
  assign map_w = (reg_addr_i inside {7'h17, 7'h18}) || (reg_addr_i >= 7'h73 && reg_addr_i <= 7'h78);
  assign low_w = reg_addr_i inside {7'h74, 7'h76, 7'h78};
  always_ff @(posedge clk_i) begin
    if (reset_i)
      cnt_q <= 8'h00;
    else if (reg_we_i && reg_addr_i == 7'h18)
      cnt_q <= reg_wdata_i;
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Past count allows the one-cycle clamp after a lower count is written
  deb_sat_a: assert property (debounce_o <= $past(cnt_q)) else $error("debounce above count");
  deb_step_a: assert property (debounce_o == $past(debounce_o) || debounce_o == $past(debounce_o) + 8'h01
    || debounce_o == $past(debounce_o) - 8'h01 || debounce_o == 8'h00 || debounce_o == cnt_q)
    else $error("debounce jumped");
  unmap_rd_a: assert property (reg_re_i && !map_w |=> reg_rdata_o == 8'h00) else $error("unmapped read");
  low_rd_a: assert property (reg_re_i && low_w |=> reg_rdata_o[1:0] == 2'h0) else $error("low bits set");
  zres_rd_a: assert property (reg_re_i && reg_addr_i == 7'h77 |=> !reg_rdata_o[7]) else $error("z bit7");
  rd_hold_a: assert property (!reg_re_i |=> $stable(reg_rdata_o)) else $error("rdata moved");
  share_bit_a: assert property (reg_we_i && reg_addr_i == 7'h75 |=> trans_share_o == $past(reg_wdata_i[7]))
    else $error("share bit");
  ev_rise_a: assert property ($rose(event_o) |-> $past(debounce_o) == $past(cnt_q)) else $error("early event");
  rst_zero_a: assert property ($fell(reset_i) |-> !event_o && debounce_o == 8'h00) else $error("reset value");
endmodule // mfd_threshold_debounce_chk

bind mfd_threshold_debounce mfd_threshold_debounce_chk mfd_threshold_debounce_chk_i (
  .clk_i(clk_i), .reset_i(reset_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .event_o(event_o), .debounce_o(debounce_o),
  .trans_share_o(trans_share_o));

/* test_mfd_threshold_debounce.sv */
module test_mfd_threshold_debounce;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SB = 4;
  localparam logic [6:0] AD [8] = '{7'h17, 7'h18, 7'h73, 7'h74, 7'h75, 7'h76, 7'h77, 7'h78};
  localparam logic [7:0] MK [8] = '{8'hff, 8'hff, 8'hff, 8'hfc, 8'hff, 8'hfc, 8'h7f, 8'hfc};
  localparam int SC [4] = '{258, 129, 64, 64};
  logic clk_i = 0, reset_i = 1, we = 0, re = 0, sv = 0, mm = 0, lat = 0, clr = 0, xyz, ev, ts;
  logic [6:0] ad = 0, ths7;
  logic [7:0] wd = 0, rdo, deb, d;
  logic [13:0] acc [3] = '{0, 0, 0};
  logic [12:0] thr [3];
  logic [2:0] en = 0, odr = 0, fl, ng;
  logic [1:0] fs = 0, pm = 0;
  int fail_count = 0, tests_run = 0, cycles = 0, n;
  mfd_threshold_debounce #(.STEP_BASE_CYCLES(SB)) mfd_threshold_debounce_i (
    .clk_i(clk_i), .reset_i(reset_i), .reg_we_i(we), .reg_re_i(re), .reg_addr_i(ad), .reg_wdata_i(wd),
    .reg_rdata_o(rdo), .sample_valid_i(sv), .accel_x_i(acc[0]), .accel_y_i(acc[1]), .accel_z_i(acc[2]),
    .axis_en_i(en), .motion_mode_i(mm), .latch_en_i(lat), .src_clear_i(clr), .full_scale_range_i(fs),
    .odr_sel_i(odr), .power_mode_i(pm), .event_o(ev), .axis_flags_o(fl), .axis_neg_o(ng), .debounce_o(deb),
    .trans_share_o(ts));
  always #20 clk_i = ~clk_i;
  // ----
  // Checking and bus tasks
  // ----
  task end_sim();
    if (fail_count == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      end_sim();
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp, input string nm);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  task wr(input logic [6:0] a, input logic [7:0] v);
    cyc(1);
    we = 1;
    ad = a;
    wd = v;
    cyc(1);
    we = 0;
  endtask
  task rd(input logic [6:0] a, input logic [7:0] e);
    cyc(1);
    re = 1;
    ad = a;
    cyc(1);
    re = 0;
    chk(rdo, e, "rdata");
  endtask
  task smp();
    sv = 1;
    cyc(1);
    sv = 0;
  endtask
  // Bounded wait for the next counter change, n gives the cycles taken
  task wait_deb();
    d = deb;
    n = 0;
    while (deb === d && n < 2100) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic logic cond_exp();
    logic hit = 0, below = (en != 0);
    int m, t;
    for (int i = 0; i < 3; i++) begin
      m = acc[i][13] ? 16384 - acc[i] : acc[i];
      t = xyz ? thr[i] : ths7 * SC[fs];
      if (en[i] && m > t) hit = 1;
      if (en[i] && !(m < t)) below = 0;
    end
    return mm ? hit : below;
  endfunction
  // Per-axis hit flags in bits 2:0 and their polarity in bits 5:3, cleared when no event
  function automatic logic [5:0] flags_exp(input logic c);
    logic [5:0] f = 6'h00;
    int m, t;
    for (int i = 0; i < 3; i++) begin
      m = acc[i][13] ? 16384 - acc[i] : acc[i];
      t = xyz ? thr[i] : ths7 * SC[fs];
      f[i] = c && en[i] && (mm ? m > t : m < t);
      f[i + 3] = f[i] && acc[i][13];
    end
    return f;
  endfunction
  function automatic int units(int o, int p);
    if (p == 2) return (o == 0) ? 1 : 2;
    if (o < 5) return 1 << o;
    if (p == 0) return 16;
    if (p == 1 || o == 5) return 64;
    return 128;
  endfunction
  // ----
  // Main sequence
  // ----
  initial begin
    void'($urandom(89618));
    cyc(6);
    reset_i = 0;
    for (int i = 0; i < 8; i++) begin
      rd(AD[i], 8'h00);
      d = 8'($urandom);
      if (i == 2) xyz = d[7];
      if (i == 4) d[7] = d[7] && !xyz;
      wr(AD[i], d);
      rd(AD[i], d & MK[i]);
      if (i == 4) chk(ts, d[7], "share");
    end
    rd(7'h20, 8'h00);
    wr(7'h18, 8'h00);
    wr(7'h75, 8'h00);
    // Count zero makes the event follow each captured condition
    for (int k = 0; k < 48; k++) begin
      xyz = 1'($urandom);
      mm = 1'($urandom);
      en = 3'($urandom);
      fs = 2'($urandom);
      ths7 = 7'($urandom_range(0, 31));
      for (int i = 0; i < 3; i++) begin
        thr[i] = 13'($urandom);
        acc[i] = (k % 4 == 0 && i == 0) ? {1'b0, thr[0]} : 14'($urandom);
      end
      wr(7'h17, {1'b0, ths7});
      for (int i = 0; i < 3; i++) begin
        wr(AD[2 + 2 * i], {(i == 0) && xyz, thr[i][12:6]});
        wr(AD[3 + 2 * i], {thr[i][5:0], 2'h0});
      end
      smp();
      cyc(2 * SB + 2);
      chk(ev, cond_exp(), "condition");
      chk(16'({ng, fl}), 16'(flags_exp(cond_exp())), "flags");
    end
    {mm, en, acc[0]} = {1'b1, 3'h1, 14'd500};
    wr(7'h73, 8'h81);
    wr(7'h74, 8'h00);
    wr(7'h17, 8'h00);
    wr(7'h18, 8'h03);
    smp();
    for (int j = 0; j < 3; j++) wait_deb();
    cyc(2 * SB + 2);
    chk(deb, 3, "saturate");
    chk(ev, 1, "event");
    acc[0] = 10;
    smp();
    wait_deb();
    chk(deb, 2, "decrement");
    cyc(1);
    chk(ev, 0, "event drop");
    wr(7'h17, 8'h80);
    acc[0] = 500;
    smp();
    // The clear-mode write lets one tick zero the counter, so count back up to the programmed value
    for (int j = 0; j < 4 && deb !== 8'h03; j++) wait_deb();
    lat = 1;
    acc[0] = 10;
    smp();
    wait_deb();
    chk(deb, 0, "clear");
    cyc(2);
    chk(ev, 1, "latched");
    clr = 1;
    cyc(1);
    clr = 0;
    lat = 0;
    cyc(1);
    chk(ev, 0, "released");
    wr(7'h18, 8'hff);
    acc[0] = 500;
    smp();
    for (int o = 0; o < 8; o++) begin
      for (int p = 0; p < 4; p++) begin
        {odr, pm} = {3'(o), 2'(p)};
        wait_deb();
        wait_deb();
        chk(16'(n), 16'(SB * units(o, p)), "step");
      end
    end
    end_sim();
  end
endmodule // test_mfd_threshold_debounce
